// ==== t2cs_top.v ====
// control and status logic of the second 16-bit multi-function timer
// assumes classic wishbone master, pins synchronous to clk_i
//
// Notes on behaviour
// R1: capture/compare mode, second capture input edge sets second capture flag.
// R2: capture/compare mode, first capture input edge sets first capture flag.
// R3: capture enable raises interrupt on each valid capture edge.
// R4: counter equal to second compare value, when active, sets its flag.
// R5: counter equal to first compare value, when active, sets its flag.
// R6: compare enable raises interrupt on each match with active compare.
// R7: counter wrap from ffff to 0000 sets overflow flag.
// R8: overflow enable raises interrupt on each counter overflow.
// R9: port read source bit picks pin levels (0) or data registers (1).
// R10: software reads data registers only with port configured as output; the code has no port direction, read source bit 1 alone selects them.
// R11: capture edge bit: 1 rising, 0 falling, for both capture inputs.
// R12: event edge bit: 1 rising, 0 falling transitions are counted.
// R13: prescale code divides system clock by two to the code.
// R14: mode code: 00 software, 01 pwm, 10 capture/compare, 11 event.
// R15: writing zero clears a flag; hardware set wins same cycle.
//
// Implementation choices: register access over Wishbone and the register offsets.

`include "t2cs_consts.vh"

module t2cs_top (
  input  wire        clk_i,                // system clock, 25 MHz
  input  wire        rst_i,                // synchronous reset, high
  input  wire        wb_cyc_i,             // bus cycle
  input  wire        wb_stb_i,             // bus strobe
  input  wire        wb_we_i,              // write enable
  input  wire [7:0]  wb_adr_i,             // byte address
  input  wire [3:0]  wb_sel_i,             // byte lanes
  input  wire [31:0] wb_dat_i,             // write data
  output reg  [31:0] wb_dat_o,             // read data
  output reg         wb_ack_o,             // acknowledge
  input  wire        capture_input_first_i, // first capture pin
  input  wire        capture_input_second_i, // second capture pin
  input  wire        event_count_input_i,  // external event pin
  input  wire [7:0]  port_pins_i,          // port pin levels
  input  wire [7:0]  port_data_i,          // port data register
  output reg  [7:0]  port_read_data_o,     // selected port read value
  output reg         port_read_source_o,   // copy of read source bit
  output reg  [15:0] timer_count_o,        // counter value
  output reg         irq_o                 // level interrupt
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // edge test shared by capture and event inputs
  function edge_hit;
    input prev;
    input cur;
    input rise;
    begin
      if (rise) begin
        edge_hit = ~prev & cur;
      end else begin
        edge_hit = prev & ~cur;
      end
    end
  endfunction

  // low bits of the prescaler that must all be set for a tick
  function [6:0] ps_mask;
    input [2:0] code;
    begin
      case (code)
        3'h0:    ps_mask = 7'h00;
        3'h1:    ps_mask = 7'h01;
        3'h2:    ps_mask = 7'h03;
        3'h3:    ps_mask = 7'h07;
        3'h4:    ps_mask = 7'h0f;
        3'h5:    ps_mask = 7'h1f;
        3'h6:    ps_mask = 7'h3f;
        default: ps_mask = 7'h7f;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg  [7:0]  flags_q;      // flag bits of flags and enables register
  reg  [7:0]  flags_d;
  reg         cap_ie_q;
  reg         cmp_ie_q;
  reg         ovf_ie_q;
  reg  [7:0]  mode_cfg_q;
  reg  [2:0]  irq_stat_q;
  reg  [2:0]  irq_stat_d;
  reg  [2:0]  irq_mask_q;
  reg  [15:0] count_q;
  reg  [15:0] count_d;
  reg  [15:0] cmp_first_q;
  reg  [15:0] cmp_second_q;
  reg         cmp_sel_q;    // 0 first compare active, 1 second
  reg  [6:0]  pre_q;
  reg         cap1_prev_q;
  reg         cap2_prev_q;
  reg         evt_prev_q;

  wire [1:0]  mode       = mode_cfg_q[`T2CS_B_MODE_HI:`T2CS_B_MODE_LO];
  wire [2:0]  ps_code    = mode_cfg_q[`T2CS_B_PS_HI:`T2CS_B_PS_LO];
  wire        cap_rise   = mode_cfg_q[`T2CS_B_CAP_EDGE];
  wire        evt_rise   = mode_cfg_q[`T2CS_B_EVT_EDGE];
  wire        mode_capcmp = (mode == `T2CS_MODE_CAPCMP);
  wire        mode_event  = (mode == `T2CS_MODE_EVENT);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr      = req & wb_we_i;
  wire        lane0   = wb_sel_i[0];
  wire        lane1   = wb_sel_i[1];
  reg         hit_fe;
  reg         hit_mc;
  reg         hit_is;
  reg         hit_im;
  reg         hit_cn;
  reg         hit_c1;
  reg         hit_c2;
  reg         hit_cs;

  always @* begin
    hit_fe = 1'b0;
    hit_mc = 1'b0;
    hit_is = 1'b0;
    hit_im = 1'b0;
    hit_cn = 1'b0;
    hit_c1 = 1'b0;
    hit_c2 = 1'b0;
    hit_cs = 1'b0;
    if (wb_adr_i == `T2CS_OFF_FLAGS_EN) begin
      hit_fe = 1'b1;
    end else if (wb_adr_i == `T2CS_OFF_MODE_CFG) begin
      hit_mc = 1'b1;
    end else if (wb_adr_i == `T2CS_OFF_IRQ_STAT) begin
      hit_is = 1'b1;
    end else if (wb_adr_i == `T2CS_OFF_IRQ_MASK) begin
      hit_im = 1'b1;
    end else if (wb_adr_i == `T2CS_OFF_COUNT) begin
      hit_cn = 1'b1;
    end else if (wb_adr_i == `T2CS_OFF_CMP_FIRST) begin
      hit_c1 = 1'b1;
    end else if (wb_adr_i == `T2CS_OFF_CMP_SECOND) begin
      hit_c2 = 1'b1;
    end else if (wb_adr_i == `T2CS_OFF_CMP_SEL) begin
      hit_cs = 1'b1;
    end
  end

  wire        wr_fe = wr & hit_fe & lane0;
  wire        wr_cn = wr & hit_cn;

  // ---------------------------------------------------------------
  // prescaler and counter
  // ---------------------------------------------------------------
  wire [6:0]  pmask   = ps_mask(ps_code);
  wire        ps_tick = ((pre_q & pmask) == pmask); // R13
  wire        evt_hit = edge_hit(evt_prev_q, event_count_input_i,
                                 evt_rise); // R12
  // event mode counts pin edges, every other mode counts ticks
  wire        advance = mode_event ? evt_hit : ps_tick; // R14
  wire        wrap    = advance & (count_q == `T2CS_COUNT_MAX);

  always @* begin
    count_d = count_q;
    if (wr_cn) begin
      if (lane0) begin
        count_d[7:0] = wb_dat_i[7:0];
      end
      if (lane1) begin
        count_d[15:8] = wb_dat_i[15:8];
      end
    end else if (advance) begin
      count_d = count_q + 16'h0001;
    end
  end

  // match tested on the value just reached, so a stopped counter
  // sitting on the compare value raises one event, not a stream
  wire        cnt_step  = advance & ~wr_cn;
  wire        cmp1_evt  = cnt_step & ~cmp_sel_q &
                          (count_d == cmp_first_q); // R5
  wire        cmp2_evt  = cnt_step & cmp_sel_q &
                          (count_d == cmp_second_q); // R4
  wire        ovf_evt   = cnt_step & wrap; // R7

  // ---------------------------------------------------------------
  // capture inputs
  // ---------------------------------------------------------------
  wire        cap1_evt = mode_capcmp &
                         edge_hit(cap1_prev_q, capture_input_first_i,
                                  cap_rise); // R2 R11
  wire        cap2_evt = mode_capcmp &
                         edge_hit(cap2_prev_q, capture_input_second_i,
                                  cap_rise); // R1 R11

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  wire [7:0]  flag_set;
  wire [7:0]  flag_clr;
  wire [7:0]  flag_bits;

  assign flag_set = {cap2_evt, cap1_evt, 1'b0, cmp2_evt, cmp1_evt,
                     1'b0, ovf_evt, 1'b0};
  assign flag_bits = 8'hda;
  // writing zero to a flag clears it; writing one leaves it alone
  assign flag_clr = {8{wr_fe}} & ~wb_dat_i[7:0];

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      always @* begin
        if (flag_bits[gi]) begin
          // set wins over a clear in the same cycle
          flags_d[gi] = flag_set[gi] |
                        (flags_q[gi] & ~flag_clr[gi]); // R15
        end else begin
          flags_d[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // ---------------------------------------------------------------
  wire [2:0]  irq_evt;
  wire [2:0]  irq_clr;

  assign irq_evt[`T2CS_I_OVF] = ovf_evt & ovf_ie_q; // R8
  assign irq_evt[`T2CS_I_CMP] = (cmp1_evt | cmp2_evt) & cmp_ie_q; // R6
  assign irq_evt[`T2CS_I_CAP] = (cap1_evt | cap2_evt) & cap_ie_q; // R3
  assign irq_clr = {3{wr & hit_is & lane0}} & wb_dat_i[2:0];

  always @* begin
    irq_stat_d = irq_evt | (irq_stat_q & ~irq_clr);
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [7:0]  fe_view = {flags_q[7:6], cap_ie_q, flags_q[4:3],
                         cmp_ie_q, flags_q[1], ovf_ie_q};
  reg  [31:0] rd_data;

  always @* begin
    rd_data = 32'h0000_0000;
    if (hit_fe) begin
      rd_data[7:0] = fe_view;
    end else if (hit_mc) begin
      rd_data[7:0] = mode_cfg_q;
    end else if (hit_is) begin
      rd_data[2:0] = irq_stat_q;
    end else if (hit_im) begin
      rd_data[2:0] = irq_mask_q;
    end else if (hit_cn) begin
      rd_data[15:0] = count_q;
    end else if (hit_c1) begin
      rd_data[15:0] = cmp_first_q;
    end else if (hit_c2) begin
      rd_data[15:0] = cmp_second_q;
    end else if (hit_cs) begin
      rd_data[0] = cmp_sel_q;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      flags_q            <= `T2CS_RST_FLAGS_EN;
      cap_ie_q           <= 1'b0;
      cmp_ie_q           <= 1'b0;
      ovf_ie_q           <= 1'b0;
      mode_cfg_q         <= `T2CS_RST_MODE_CFG;
      irq_stat_q         <= `T2CS_RST_IRQ;
      irq_mask_q         <= `T2CS_RST_IRQ;
      count_q            <= `T2CS_RST_COUNT;
      cmp_first_q        <= `T2CS_RST_CMP;
      cmp_second_q       <= `T2CS_RST_CMP;
      cmp_sel_q          <= 1'b0;
      pre_q              <= `T2CS_RST_PRE;
      cap1_prev_q        <= 1'b0;
      cap2_prev_q        <= 1'b0;
      evt_prev_q         <= 1'b0;
      wb_ack_o           <= 1'b0;
      wb_dat_o           <= 32'h0000_0000;
      irq_o              <= 1'b0;
      port_read_source_o <= 1'b0;
      port_read_data_o   <= 8'h00;
      timer_count_o      <= `T2CS_RST_COUNT;
    end else begin
      flags_q     <= flags_d;
      irq_stat_q  <= irq_stat_d;
      count_q     <= count_d;
      pre_q       <= pre_q + 7'h01;
      cap1_prev_q <= capture_input_first_i;
      cap2_prev_q <= capture_input_second_i;
      evt_prev_q  <= event_count_input_i;
      if (wr_fe) begin
        cap_ie_q <= wb_dat_i[`T2CS_B_CAP_IE];
        cmp_ie_q <= wb_dat_i[`T2CS_B_CMP_IE];
        ovf_ie_q <= wb_dat_i[`T2CS_B_OVF_IE];
      end
      if (wr & hit_mc & lane0) begin
        mode_cfg_q <= wb_dat_i[7:0];
      end
      if (wr & hit_im & lane0) begin
        irq_mask_q <= wb_dat_i[2:0];
      end
      if (wr & hit_c1) begin
        if (lane0) begin
          cmp_first_q[7:0] <= wb_dat_i[7:0];
        end
        if (lane1) begin
          cmp_first_q[15:8] <= wb_dat_i[15:8];
        end
      end
      if (wr & hit_c2) begin
        if (lane0) begin
          cmp_second_q[7:0] <= wb_dat_i[7:0];
        end
        if (lane1) begin
          cmp_second_q[15:8] <= wb_dat_i[15:8];
        end
      end
      if (wr & hit_cs & lane0) begin
        cmp_sel_q <= wb_dat_i[0];
      end
      // one wait state: ack in the cycle after the request is seen
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        wb_dat_o <= rd_data;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
      irq_o              <= |(irq_stat_d & irq_mask_q);
      port_read_source_o <= mode_cfg_q[`T2CS_B_PORT_RD];
      // data register view is only meaningful for output pins
      if (mode_cfg_q[`T2CS_B_PORT_RD]) begin // R9 R10
        port_read_data_o <= port_data_i;
      end else begin
        port_read_data_o <= port_pins_i;
      end
      timer_count_o <= count_d;
    end
  end

endmodule

// ==== t2cs_consts.vh ====
// constants of the second timer control and status block
// assumes a 32-bit classic wishbone bus with byte addresses
`ifndef T2CS_CONSTS_VH
`define T2CS_CONSTS_VH

// register byte offsets
`define T2CS_OFF_FLAGS_EN   8'h00
`define T2CS_OFF_MODE_CFG   8'h04
`define T2CS_OFF_IRQ_STAT   8'h08
`define T2CS_OFF_IRQ_MASK   8'h0c
`define T2CS_OFF_COUNT      8'h10
`define T2CS_OFF_CMP_FIRST  8'h14
`define T2CS_OFF_CMP_SECOND 8'h18
`define T2CS_OFF_CMP_SEL    8'h1c

// flags and enables register fields
`define T2CS_B_CAP_F2       7
`define T2CS_B_CAP_F1       6
`define T2CS_B_CAP_IE       5
`define T2CS_B_CMP_F2       4
`define T2CS_B_CMP_F1       3
`define T2CS_B_CMP_IE       2
`define T2CS_B_OVF_F        1
`define T2CS_B_OVF_IE       0

// mode and configuration register fields
`define T2CS_B_PORT_RD      7
`define T2CS_B_CAP_EDGE     6
`define T2CS_B_EVT_EDGE     5
`define T2CS_B_PS_HI        4
`define T2CS_B_PS_LO        2
`define T2CS_B_MODE_HI      1
`define T2CS_B_MODE_LO      0

// interrupt status and mask fields
`define T2CS_I_OVF          0
`define T2CS_I_CMP          1
`define T2CS_I_CAP          2

// operating modes
`define T2CS_MODE_SOFT      2'h0
`define T2CS_MODE_PWM       2'h1
`define T2CS_MODE_CAPCMP    2'h2
`define T2CS_MODE_EVENT     2'h3

// reset values
`define T2CS_RST_FLAGS_EN   8'h00
`define T2CS_RST_MODE_CFG   8'h00
`define T2CS_RST_IRQ        3'h0
`define T2CS_RST_COUNT      16'h0000
`define T2CS_RST_CMP        16'hffff
`define T2CS_RST_PRE        7'h00

// counter limits
`define T2CS_COUNT_MAX      16'hffff

`endif

// ==== t2cs_pins_model.sv ====
// far-side pin driver: capture, event and port pins of the block
// assumes clk_i is the block clock; pins change just after rising edges
module t2cs_pins_model (
  input  wire       clk_i,  // system clock
  output reg        cap1_o, // first capture pin
  output reg        cap2_o, // second capture pin
  output reg        evt_o,  // event count pin
  output reg  [7:0] pins_o  // port pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cap1_o = 1'b0;
    cap2_o = 1'b0;
    evt_o = 1'b0;
    pins_o = 8'h00;
  end
  // one pin flips, then time for the edge to reach the flags
  task flip(input int which);
    @(posedge clk_i);
    case (which)
      0: cap1_o <= ~cap1_o;
      1: cap2_o <= ~cap2_o;
      default: evt_o <= ~evt_o;
    endcase
    repeat (3) @(posedge clk_i);
  endtask
  // outside circuit forcing the port pins against the data register
  task drive(input [7:0] v);
    @(posedge clk_i);
    pins_o <= v;
  endtask
endmodule

// ==== t2cs_top_checker.sv ====
// port assertions of the timer control and status block
// assumes it is bound into t2cs_top, one clock domain
`include "t2cs_consts.vh"
module t2cs_top_checker (
  input wire        clk_i,              // clock
  input wire        rst_i,              // reset
  input wire        wb_cyc_i,           // cycle
  input wire        wb_stb_i,           // strobe
  input wire        wb_we_i,            // write
  input wire [7:0]  wb_adr_i,           // address
  input wire [31:0] wb_dat_o,           // read data
  input wire        wb_ack_o,           // ack
  input wire [7:0]  port_pins_i,        // pin levels
  input wire [7:0]  port_data_i,        // data register
  input wire [7:0]  port_read_data_o,   // port read value
  input wire        port_read_source_o, // read source
  input wire [15:0] timer_count_o,      // counter
  input wire        irq_o               // interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_any = take & wb_we_i;
  wire wr_cnt = wr_any & (wb_adr_i == `T2CS_OFF_COUNT);
  wire wr_cfg = wr_any & (wb_adr_i == `T2CS_OFF_MODE_CFG);
  sequence s_take;
    take;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_once: assert property (s_take |=> s_ack)
    else $error("ack not a single pulse");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_dat_upper: assert property (wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits not zero");
  chk_port_mux: assert property (!$past(rst_i) |->
    port_read_data_o ==
    (port_read_source_o ? $past(port_data_i) : $past(port_pins_i)))
    else $error("port read value from wrong source");
  chk_src_hold: assert property ($changed(port_read_source_o) |->
    $past(wr_cfg, 2))
    else $error("read source changed without write");
  chk_cnt_step: assert property (!$past(rst_i) && !$past(wr_cnt) |->
    timer_count_o - $past(timer_count_o) <= 16'h1)
    else $error("counter jumped");
  chk_irq_sticky: assert property (!$past(rst_i) && $fell(irq_o) |->
    $past(wr_any))
    else $error("interrupt dropped without a write");
endmodule

// ==== t2cs_top_tb.sv ====
// self-checking bench of the timer control and status block
// assumes the pin model on the far side and the port checker bound in
`include "t2cs_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module t2cs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [7:0] a_fe = `T2CS_OFF_FLAGS_EN;
  localparam [7:0] a_mc = `T2CS_OFF_MODE_CFG;
  localparam [7:0] a_is = `T2CS_OFF_IRQ_STAT;
  localparam [7:0] a_im = `T2CS_OFF_IRQ_MASK;
  localparam [7:0] a_cn = `T2CS_OFF_COUNT;
  reg         clk_i = 1'b0;
  reg         rst_i;
  reg         wb_cyc_i;
  reg         wb_stb_i;
  reg         wb_we_i;
  reg  [7:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i;
  reg  [7:0]  port_data_i;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, cap1, cap2, evt, port_read_source_o, irq_o;
  wire [7:0]  pins, port_read_data_o;
  wire [15:0] timer_count_o;
  int         error_cnt = 0;
  int         comparisons = 0;
  always #20 clk_i = ~clk_i;
  t2cs_top t2cs_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .capture_input_first_i(cap1), .capture_input_second_i(cap2),
    .event_count_input_i(evt), .port_pins_i(pins),
    .port_data_i(port_data_i), .port_read_data_o(port_read_data_o),
    .port_read_source_o(port_read_source_o),
    .timer_count_o(timer_count_o), .irq_o(irq_o));
  t2cs_pins_model pins_m (.clk_i(clk_i), .cap1_o(cap1), .cap2_o(cap2),
    .evt_o(evt), .pins_o(pins));
  task end_of_test;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wb(input [7:0] a, input w, input [3:0] s, input [31:0] d,
          output [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("MISMATCH t=%0t no bus acknowledge", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    wb(a, 1'b1, 4'hf, d, q);
  endtask
  // write with chosen byte lanes
  task wrs(input [7:0] a, input [3:0] s, input [31:0] d);
    reg [31:0] q;
    wb(a, 1'b1, s, d, q);
  endtask
  task rc(input [7:0] a, input [31:0] e);
    reg [31:0] q;
    wb(a, 1'b0, 4'hf, 32'h0, q);
    `CHK(q, e)
  endtask
  // cycles until the next counter step, as seen at the port
  task step(output int n);
    reg [15:0] c;
    c = timer_count_o;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (timer_count_o === c && n < 300);
  endtask
  task t_reset;
    rc(a_mc, 32'h0);
    rc(`T2CS_OFF_CMP_FIRST, 32'hffff);
    wr(8'h20, 32'hff);
    rc(8'h20, 32'h0);
    wrs(a_mc, 4'he, 32'hff);
    rc(a_mc, 32'h0);
    wrs(`T2CS_OFF_CMP_FIRST, 4'h1, 32'h1234);
    rc(`T2CS_OFF_CMP_FIRST, 32'hff34);
    wrs(`T2CS_OFF_CMP_FIRST, 4'h2, 32'h5678);
    rc(`T2CS_OFF_CMP_FIRST, 32'h5634);
  endtask
  task t_prescale;
    int n;
    for (int k = 0; k < 8; k++) begin
      wr(a_mc, {27'h0, k[2:0], 1'b0, k[0]});
      step(n);
      step(n);
      `CHK(n, 1 << k)
    end
  endtask
  task t_event;
    wr(a_mc, 32'h23);
    wr(a_cn, 32'h0);
    repeat (3) pins_m.flip(2);
    `CHK(timer_count_o, 16'h0002)
    wr(a_mc, 32'h03);
    pins_m.flip(2);
    `CHK(timer_count_o, 16'h0003)
  endtask
  task t_capture;
    wr(a_mc, 32'h5e);
    wr(a_cn, 32'h0);
    wr(a_is, 32'h7);
    wr(a_im, 32'h4);
    wr(a_fe, 32'h20);
    pins_m.flip(0);
    rc(a_fe, 32'h60);
    `CHK(irq_o, 1'b1)
    wr(a_fe, 32'he0);
    rc(a_fe, 32'h60);
    wr(a_fe, 32'h20);
    wr(a_is, 32'h4);
    `CHK(irq_o, 1'b0)
    wr(a_mc, 32'h1e);
    pins_m.flip(1);
    rc(a_fe, 32'h20);
    pins_m.flip(1);
    rc(a_fe, 32'ha0);
    `CHK(irq_o, 1'b1)
    wr(a_fe, 32'h0);
    wr(a_is, 32'h4);
    pins_m.flip(0);
    rc(a_fe, 32'h40);
    rc(a_is, 32'h0);
    wr(a_mc, 32'h5c);
    pins_m.flip(0);
    rc(a_fe, 32'h40);
  endtask
  task t_compare;
    wr(`T2CS_OFF_CMP_FIRST, 32'h10);
    wr(`T2CS_OFF_CMP_SEL, 32'h0);
    wr(a_mc, 32'h0);
    wr(a_cn, 32'h0);
    wr(a_fe, 32'h04);
    wr(a_is, 32'h7);
    wr(a_im, 32'h2);
    repeat (30) @(posedge clk_i);
    rc(a_fe, 32'h0c);
    `CHK(irq_o, 1'b1)
    wr(`T2CS_OFF_CMP_SECOND, 32'h20);
    wr(`T2CS_OFF_CMP_SEL, 32'h1);
    wr(a_cn, 32'h0);
    wr(a_fe, 32'h04);
    wr(a_is, 32'h7);
    repeat (40) @(posedge clk_i);
    rc(a_fe, 32'h14);
    `CHK(irq_o, 1'b1)
    wr(a_fe, 32'h0);
    wr(a_is, 32'h7);
    wr(a_cn, 32'h0);
    repeat (40) @(posedge clk_i);
    rc(a_fe, 32'h10);
    rc(a_is, 32'h0);
  endtask
  task t_overflow;
    wr(a_im, 32'h1);
    wr(a_cn, 32'hfff0);
    wr(a_fe, 32'h01);
    wr(a_is, 32'h7);
    repeat (20) @(posedge clk_i);
    rc(a_fe, 32'h03);
    `CHK(irq_o, 1'b1)
    rc(a_is, 32'h1);
    wr(a_cn, 32'hfff0);
    wr(a_fe, 32'h0);
    wr(a_is, 32'h7);
    repeat (20) @(posedge clk_i);
    rc(a_fe, 32'h02);
    rc(a_is, 32'h0);
  endtask
  task t_port;
    port_data_i <= 8'ha5;
    pins_m.drive(8'h5a);
    repeat (2) @(posedge clk_i);
    `CHK(port_read_data_o, 8'h5a)
    wr(a_mc, 32'h80);
    repeat (2) @(posedge clk_i);
    `CHK(port_read_data_o, 8'ha5)
    `CHK(port_read_source_o, 1'b1)
  endtask
  // reset in mid-run with an interrupt pending
  task t_rerst;
    wr(a_fe, 32'h01);
    wr(a_cn, 32'hfff8);
    repeat (12) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK(irq_o, 1'b0)
    `CHK(port_read_source_o, 1'b0)
    rc(a_fe, 32'h0);
    rc(a_is, 32'h0);
    rc(a_im, 32'h0);
    rc(`T2CS_OFF_CMP_SECOND, 32'hffff);
  endtask
  initial begin
    rst_i <= 1'b1;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_adr_i <= 8'h00;
    wb_sel_i <= 4'hf;
    wb_dat_i <= 32'h0;
    port_data_i <= 8'h00;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_prescale;
    t_event;
    t_capture;
    t_compare;
    t_overflow;
    t_port;
    t_rerst;
    end_of_test;
  end
  // whole run is about one thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test;
  end
endmodule
bind t2cs_top t2cs_top_checker t2cs_top_checker_inst (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .port_pins_i(port_pins_i),
  .port_data_i(port_data_i), .port_read_data_o(port_read_data_o),
  .port_read_source_o(port_read_source_o),
  .timer_count_o(timer_count_o), .irq_o(irq_o));
